// File: inc/trim_consts.svh
// Purpose: Offsets, field positions, reset values for the core trim bank
// Assumes: Register port with byte-granular offsets, 16-bit data
// Notes:   Definitions only
`ifndef TRIM_CONSTS_SVH
`define TRIM_CONSTS_SVH
`define ADDR_TIMING_B_DE_INB  12'h31B
`define ADDR_OFS_A_P0_INA     12'h344
`define ADDR_OFS_A_P0_INB     12'h346
`define ADDR_OFS_A_P90_INA    12'h348
`define ADDR_OFS_A_P90_INB    12'h34A
`define ADDR_OFS_B_P0_INA     12'h34C
`define ADDR_FUSE_STATUS      12'h3F0
`define TIMING_MSB            7
`define OFS_MSB               11
`define RSVD_MSB              15
`define RSVD_LSB              12
`define TIMING_RESET          8'h00
`define NUM_TRIMS             6
`define FUSE_IDX_W            3
`endif

// File: inc/trim_pkg.sv
// Purpose: Types for the core trim bank
// Assumes: Nothing beyond the constants header
// Notes:   Trim indices follow the fuse storage order
package trim_pkg;
   typedef enum logic [2:0] {
      TRIM_TIMING_B_DE_INB,
      TRIM_OFS_A_P0_INA,
      TRIM_OFS_A_P0_INB,
      TRIM_OFS_A_P90_INA,
      TRIM_OFS_A_P90_INB,
      TRIM_OFS_B_P0_INA
   } trim_idx_e;
   typedef enum logic {
      LOAD_BUSY,
      LOAD_DONE
   } load_state_e;
endpackage : trim_pkg

// File: src/fuse_loader.sv
// Purpose: Walk the fuse storage once after reset and hand each default out
// Assumes: Fuse data valid one cycle after its index is presented
// Notes:   One trim per two cycles; done is a level held until next reset
`timescale 1ns/1ns
`include "trim_consts.svh"
module fuse_loader
   import trim_pkg::*;
(
   // Clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   nrst_i,
   // Fuse storage side
   output logic [`FUSE_IDX_W-1:0]      fuse_idx_o,
   input  wire logic [15:0]            fuse_data_i,
   // Load strobe to the bank
   output logic                        load_we_o,
   output logic [`FUSE_IDX_W-1:0]      load_idx_o,
   output logic [15:0]                 load_data_o,
   output logic                        done_o
);
   load_state_e                state;
   logic [`FUSE_IDX_W-1:0]     idx;
   logic                       phase;
   wire                        last = (idx == 3'(`NUM_TRIMS - 1));

   //////////////////////////////////////////////////////////////////
   // Present index, capture data on the second cycle of each slot
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state       <= LOAD_BUSY;
         idx         <= '0;
         phase       <= 1'b0;
         load_we_o   <= 1'b0;
         load_idx_o  <= '0;
         load_data_o <= 16'h0000;
      end else begin
         load_we_o <= 1'b0;
         unique case (state)
            LOAD_BUSY: begin
               phase <= ~phase;
               if (phase) begin
                  load_we_o   <= 1'b1;
                  load_idx_o  <= idx;
                  load_data_o <= fuse_data_i;
                  if (last) state <= LOAD_DONE;
                  else idx <= idx + 3'h1;
               end
            end
            LOAD_DONE: ;
         endcase
      end
   end

   assign fuse_idx_o = idx;
   assign done_o     = (state == LOAD_DONE) && !load_we_o;
endmodule : fuse_loader

// File: src/offset_select.sv
// Purpose: Pick the one offset trim for each core from the operating state
// Assumes: Mode inputs already on sys_clk
// Notes:   Zero offset when foreground calibration is off
`timescale 1ns/1ns
module offset_select (
   // Operating state
   input  wire logic         fg_cal_en_i,
   input  wire logic         a_in_sel_b_i,
   input  wire logic         a_phase90_i,
   input  wire logic         b_in_sel_b_i,
   // Stored trims
   input  wire logic [11:0]  ofs_a_p0_ina_i,
   input  wire logic [11:0]  ofs_a_p0_inb_i,
   input  wire logic [11:0]  ofs_a_p90_ina_i,
   input  wire logic [11:0]  ofs_a_p90_inb_i,
   input  wire logic [11:0]  ofs_b_p0_ina_i,
   // Chosen trims
   output logic [11:0]       ofs_a_o,
   output logic [11:0]       ofs_b_o
);
   // A core: four way choice by phase then input
   wire [11:0] a_p0  = a_in_sel_b_i ? ofs_a_p0_inb_i  : ofs_a_p0_ina_i;
   wire [11:0] a_p90 = a_in_sel_b_i ? ofs_a_p90_inb_i : ofs_a_p90_ina_i;
   assign ofs_a_o = !fg_cal_en_i ? 12'h000 : (a_phase90_i ? a_p90 : a_p0);
   // B core: only input A trim lives in this bank; input B gives zero
   assign ofs_b_o = (fg_cal_en_i && !b_in_sel_b_i) ? ofs_b_p0_ina_i : 12'h000;
endmodule : offset_select

// File: src/core_trim_bank.sv
// Purpose: Software trim registers for a dual-core converter
// Assumes: Fuse storage and mode pins supplied by the surrounding chip
// Notes:   Register port is plain strobes; read data one cycle later
// Contract
// [RULE1] 8-bit read/write B-core timing trim for dual-edge, calibrated, input B.
// [RULE2] 12-bit A-core offset for input A, 0 degree phase, calibration on.
// [RULE3] Separate 12-bit A-core offset for input B, 0 degree phase.
// [RULE4] Distinct 12-bit A-core offset for input A, 90 degree phase.
// [RULE5] Distinct 12-bit A-core offset for input B, 90 degree phase.
// [RULE6] Read/write B-core offset for input A, low twelve bits of sixteen.
// [RULE7] Defaults load from fuses at startup; offset bits 15-12 reserved.
// [RULE8] Timing trim shifts sampling instant of the core and mode it serves.
// [RULE9] Software may read defaults and overwrite; written values then used.
// [RULE10] Exactly one offset per core chosen from core, input, phase, calibration.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`include "trim_consts.svh"
module core_trim_bank
   import trim_pkg::*;
(
   // Clock and reset
   input  wire logic          sys_clk_i,
   input  wire logic          nrst_i,
   // Register port
   input  wire logic [11:0]   reg_addr_i,
   input  wire logic [15:0]   reg_wdata_i,
   input  wire logic          reg_wr_i,
   input  wire logic          reg_rd_i,
   output logic [15:0]        reg_rdata_o,
   // Fuse storage
   output logic [2:0]         fuse_idx_o,
   input  wire logic [15:0]   fuse_data_i,
   // Operating mode pins (asynchronous)
   input  wire logic          dual_edge_i,
   input  wire logic          fg_cal_en_i,
   input  wire logic          a_in_sel_b_i,
   input  wire logic          a_phase90_i,
   input  wire logic          b_in_sel_b_i,
   // Trims to the cores
   output logic [7:0]         timing_b_o,
   output logic               timing_b_valid_o,
   output logic [11:0]        ofs_a_o,
   output logic [11:0]        ofs_b_o,
   output logic               trims_ready_o
);
   //////////////////////////////////////////////////////////////////
   // Storage
   logic [7:0]   timing_trim_b_dual_edge_inb;
   logic [15:0]  ofs_reg [0:4];
   logic [4:0]   mode_s1;
   logic [4:0]   mode_s2;
   logic         load_we;
   logic [2:0]   load_idx;
   logic [15:0]  load_data;
   logic         load_done;
   logic [11:0]  sel_a;
   logic [11:0]  sel_b;

   // Address to offset slot, 3'h7 when not an offset register
   function automatic logic [2:0] ofs_slot(input logic [11:0] a);
      unique case (a)
         `ADDR_OFS_A_P0_INA:  ofs_slot = 3'h0;
         `ADDR_OFS_A_P0_INB:  ofs_slot = 3'h1;
         `ADDR_OFS_A_P90_INA: ofs_slot = 3'h2;
         `ADDR_OFS_A_P90_INB: ofs_slot = 3'h3;
         `ADDR_OFS_B_P0_INA:  ofs_slot = 3'h4;
         default:             ofs_slot = 3'h7;
      endcase
   endfunction : ofs_slot

   //////////////////////////////////////////////////////////////////
   // Startup load from fuses
   fuse_loader u_loader (
      .sys_clk_i   (sys_clk_i),
      .nrst_i      (nrst_i),
      .fuse_idx_o  (fuse_idx_o),
      .fuse_data_i (fuse_data_i),
      .load_we_o   (load_we),
      .load_idx_o  (load_idx),
      .load_data_o (load_data),
      .done_o      (load_done)
   );

   // Mode pins come from outside the clock domain
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_s1 <= 5'h00;
         mode_s2 <= 5'h00;
      end else begin
         mode_s1 <= {dual_edge_i, fg_cal_en_i, a_in_sel_b_i, a_phase90_i, b_in_sel_b_i};
         mode_s2 <= mode_s1;
      end
   end

   wire m_dual  = mode_s2[4];
   wire m_fg    = mode_s2[3];
   wire m_a_inb = mode_s2[2];
   wire m_a_p90 = mode_s2[1];
   wire m_b_inb = mode_s2[0];

   //////////////////////////////////////////////////////////////////
   // Write decode; software writes are dropped until fuse load ends
   wire        sw_wr      = reg_wr_i && load_done;
   wire [2:0]  wr_slot    = ofs_slot(reg_addr_i);
   wire        wr_timing  = sw_wr && (reg_addr_i == `ADDR_TIMING_B_DE_INB);
   wire        ld_timing  = load_we && (load_idx == 3'(TRIM_TIMING_B_DE_INB));
   wire [2:0]  ld_slot    = load_idx - 3'h1;

   // Timing trim register
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) timing_trim_b_dual_edge_inb <= `TIMING_RESET;  // see [RULE1]
      else if (ld_timing) timing_trim_b_dual_edge_inb <= load_data[`TIMING_MSB:0]; // see [RULE7]
      else if (wr_timing) timing_trim_b_dual_edge_inb <= reg_wdata_i[`TIMING_MSB:0]; // see [RULE9]
   end

   // Offset registers, all sixteen bits kept (reserved bits are R/W)
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < 5; i++) ofs_reg[i] <= 16'h0000;
      end else if (load_we && !ld_timing) begin
         ofs_reg[ld_slot] <= load_data;  // see [RULE7]
      end else if (sw_wr && wr_slot != 3'h7) begin
         ofs_reg[wr_slot] <= reg_wdata_i;  // see [RULE6] see [RULE9]
      end
   end

   //////////////////////////////////////////////////////////////////
   // Read port: data stands in the cycle after the strobe only
   wire [2:0]  rd_slot = ofs_slot(reg_addr_i);
   wire [15:0] rd_mux  =
      (reg_addr_i == `ADDR_TIMING_B_DE_INB) ? {8'h00, timing_trim_b_dual_edge_inb} :
      (reg_addr_i == `ADDR_FUSE_STATUS)     ? {15'h0000, load_done} :
      (rd_slot != 3'h7)                     ? ofs_reg[rd_slot] : 16'h0000;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) reg_rdata_o <= 16'h0000;
      else reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
   end

   //////////////////////////////////////////////////////////////////
   // Offset choice per core
   offset_select u_sel (
      .fg_cal_en_i     (m_fg),
      .a_in_sel_b_i    (m_a_inb),
      .a_phase90_i     (m_a_p90),
      .b_in_sel_b_i    (m_b_inb),
      .ofs_a_p0_ina_i  (ofs_reg[0][`OFS_MSB:0]),  // see [RULE2]
      .ofs_a_p0_inb_i  (ofs_reg[1][`OFS_MSB:0]),  // see [RULE3]
      .ofs_a_p90_ina_i (ofs_reg[2][`OFS_MSB:0]),  // see [RULE4]
      .ofs_a_p90_inb_i (ofs_reg[3][`OFS_MSB:0]),  // see [RULE5]
      .ofs_b_p0_ina_i  (ofs_reg[4][`OFS_MSB:0]),  // see [RULE6]
      .ofs_a_o         (sel_a),
      .ofs_b_o         (sel_b)
   );

   // Registered outputs to the cores; reserved bits never reach them
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ofs_a_o          <= 12'h000;
         ofs_b_o          <= 12'h000;
         timing_b_o       <= 8'h00;
         timing_b_valid_o <= 1'b0;
      end else begin
         ofs_a_o          <= sel_a;  // see [RULE10]
         ofs_b_o          <= sel_b;  // see [RULE10]
         timing_b_o       <= timing_trim_b_dual_edge_inb;  // see [RULE8]
         timing_b_valid_o <= m_dual && m_fg && m_b_inb;  // see [RULE1] see [RULE8]
      end
   end

   assign trims_ready_o = load_done;

   //////////////////////////////////////////////////////////////////
   // Checks on the register side
   // Edges since reset release, saturating, so the fuse walk length
   // can be pinned without a long repetition
   logic [4:0] since_rst;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) since_rst <= 5'h00;
      else if (since_rst != 5'h1F) since_rst <= since_rst + 5'h01;
   end

   // Software write to the timing trim lands next edge
   a_timing_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE1]
      wr_timing |=> timing_trim_b_dual_edge_inb == $past(reg_wdata_i[7:0]))
      else $error("timing trim write lost");
   // Timing trim reads back zero-extended
   a_read_timing: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE1]
      (reg_rd_i && reg_addr_i == `ADDR_TIMING_B_DE_INB) |=>
         reg_rdata_o == {8'h00, $past(timing_trim_b_dual_edge_inb)})
      else $error("timing trim read back wrong");
   // Timing trim moves only on a fuse load or a software write
   a_timing_hold: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE9]
      (!wr_timing && !ld_timing) |=> $stable(timing_trim_b_dual_edge_inb))
      else $error("timing trim changed unasked");
   // Writes before the fuse walk ends are dropped
   a_early_wr_drop: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE7]
      (reg_wr_i && !load_done && !ld_timing) |=> $stable(timing_trim_b_dual_edge_inb))
      else $error("write accepted during fuse load");
   // Fuse default reaches the timing trim
   a_load_timing: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE7]
      ld_timing |=> timing_trim_b_dual_edge_inb == $past(load_data[7:0]))
      else $error("timing default not loaded");
   // Fuse default reaches each offset register
   a_fuse_load_ofs: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE7]
      (load_we && !ld_timing) |=> ofs_reg[$past(ld_slot)] == $past(load_data))
      else $error("fuse default not loaded");
   // Fuse walk has a fixed length, never short
   a_load_length: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE7]
      trims_ready_o == (since_rst >= 5'h0D))
      else $error("fuse walk length wrong");
   // Load strobes are single cycles, one slot apart
   a_load_we_pulse: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE7]
      load_we |=> !load_we)
      else $error("load strobe too long");
   // Ready is a level held until the next reset
   a_done_holds: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE7]
      trims_ready_o |=> trims_ready_o)
      else $error("ready dropped");
   // Fuse index never leaves the six trims
   a_fuse_idx_range: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE7]
      fuse_idx_o <= 3'h5)
      else $error("fuse index out of range");
   // Software write to an offset lands next edge, all sixteen bits
   a_ofs_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE9]
      (sw_wr && wr_slot != 3'h7) |=> ofs_reg[$past(wr_slot)] == $past(reg_wdata_i))
      else $error("offset write lost");
   // Offset read back, one per register
   a_read_back: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE9]
      (reg_rd_i && reg_addr_i == `ADDR_OFS_A_P0_INA) |=> reg_rdata_o == $past(ofs_reg[0]))
      else $error("offset read back wrong");
   a_read_p0_inb: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE3]
      (reg_rd_i && reg_addr_i == `ADDR_OFS_A_P0_INB) |=> reg_rdata_o == $past(ofs_reg[1]))
      else $error("phase0 input B read back wrong");
   a_read_p90_ina: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE4]
      (reg_rd_i && reg_addr_i == `ADDR_OFS_A_P90_INA) |=> reg_rdata_o == $past(ofs_reg[2]))
      else $error("phase90 input A read back wrong");
   a_read_p90_inb: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE5]
      (reg_rd_i && reg_addr_i == `ADDR_OFS_A_P90_INB) |=> reg_rdata_o == $past(ofs_reg[3]))
      else $error("phase90 input B read back wrong");
   a_read_b_ina: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE6]
      (reg_rd_i && reg_addr_i == `ADDR_OFS_B_P0_INA) |=> reg_rdata_o == $past(ofs_reg[4]))
      else $error("B offset read back wrong");
   // Status shows the load state
   a_read_status: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE7]
      (reg_rd_i && reg_addr_i == `ADDR_FUSE_STATUS) |=>
         reg_rdata_o == {15'h0000, $past(load_done)})
      else $error("status read wrong");
   // Unmapped addresses read zero
   a_read_unmapped: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE9]
      (reg_rd_i && rd_slot == 3'h7 && reg_addr_i != `ADDR_TIMING_B_DE_INB &&
         reg_addr_i != `ADDR_FUSE_STATUS) |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   // Read data stands one cycle only
   a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE9]
      !reg_rd_i |=> reg_rdata_o == 16'h0000)
      else $error("read data outside its cycle");

   //////////////////////////////////////////////////////////////////
   // Checks on the core side
   // A core offset, one per input and phase
   a_ofs_a_p0_ina: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE2]
      (m_fg && !m_a_p90 && !m_a_inb) |=> ofs_a_o == $past(ofs_reg[0][11:0]))
      else $error("A offset phase0 input A wrong");
   a_ofs_a_p0_inb: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE3]
      (m_fg && !m_a_p90 && m_a_inb) |=> ofs_a_o == $past(ofs_reg[1][11:0]))
      else $error("A offset phase0 input B wrong");
   a_ofs_a_p90_ina: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE4]
      (m_fg && m_a_p90 && !m_a_inb) |=> ofs_a_o == $past(ofs_reg[2][11:0]))
      else $error("A offset phase90 input A wrong");
   a_ofs_a_p90_inb: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE5]
      (m_fg && m_a_p90 && m_a_inb) |=> ofs_a_o == $past(ofs_reg[3][11:0]))
      else $error("A offset phase90 input B wrong");
   // B core offset: input A from the bank, input B has none here
   a_ofs_b_ina: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE6]
      (m_fg && !m_b_inb) |=> ofs_b_o == $past(ofs_reg[4][11:0]))
      else $error("B offset input A wrong");
   a_ofs_b_inb_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE10]
      m_b_inb |=> ofs_b_o == 12'h000)
      else $error("B offset applied on input B");
   // No offset without foreground calibration
   a_cal_off_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE10]
      !m_fg |=> (ofs_a_o == 12'h000 && ofs_b_o == 12'h000))
      else $error("offset applied without calibration");
   // Timing trim flagged only in its own mode, always copied
   a_timing_valid: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE8]
      (m_dual && m_fg && m_b_inb) |=>
         timing_b_valid_o && timing_b_o == $past(timing_trim_b_dual_edge_inb))
      else $error("timing trim not presented");
   a_timing_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE8]
      !(m_dual && m_fg && m_b_inb) |=> !timing_b_valid_o)
      else $error("timing trim flagged out of mode");
   a_timing_copy: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)  // see [RULE8]
      1'b1 |=> timing_b_o == $past(timing_trim_b_dual_edge_inb))
      else $error("timing trim copy stale");
endmodule : core_trim_bank

// File: verification/test_adc_core_trim_registers.sv
// Purpose: Self-checking bench for the core trim bank
// Assumes: Fuse storage answers one cycle after the index, mode pins settle in 3 edges
// Notes:   Table rows for registers and mode selection, hand tests for reset cases
`timescale 1ns/1ns
`include "trim_consts.svh"
module test_adc_core_trim_registers;
   import trim_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Design ports
   logic        sys_clk_i;
   logic        nrst_i;
   logic [11:0] reg_addr_i;
   logic [15:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [15:0] reg_rdata_o;
   logic [2:0]  fuse_idx_o;
   logic [15:0] fuse_data_i;
   logic        dual_edge_i, fg_cal_en_i, a_in_sel_b_i, a_phase90_i, b_in_sel_b_i;
   logic [7:0]  timing_b_o;
   logic        timing_b_valid_o;
   logic [11:0] ofs_a_o;
   logic [11:0] ofs_b_o;
   logic        trims_ready_o;
   int          fails;
   int          checked;
   int          n;
   logic [15:0] rv;

   // Fuse words with reserved bits set, so lost upper bits show up
   logic [15:0] rom [6] = '{16'h00A5, 16'hF123, 16'hE456, 16'hD789, 16'hCABC, 16'hBDEF};
   // Register rows: address, default, write data, read back after write
   logic [11:0] r_ad [8] = '{12'h31B, 12'h344, 12'h346, 12'h348, 12'h34A, 12'h34C,
                             12'h300, 12'h3F0};
   logic [15:0] r_df [8] = '{16'h00A5, 16'hF123, 16'hE456, 16'hD789, 16'hCABC, 16'hBDEF,
                             16'h0000, 16'h0001};
   logic [15:0] r_wd [8] = '{16'hFF3C, 16'h0A01, 16'h1B02, 16'h2C03, 16'h3D04, 16'h4E05,
                             16'hFFFF, 16'h0000};
   logic [15:0] r_rb [8] = '{16'h003C, 16'h0A01, 16'h1B02, 16'h2C03, 16'h3D04, 16'h4E05,
                             16'h0000, 16'h0001};
   // Mode rows: {dual, fg, a_in_b, a_90, b_in_b}, A offset, B offset, valid
   logic [4:0]  m_md [7] = '{5'b00000, 5'b11000, 5'b01100, 5'b01010, 5'b11111, 5'b10111,
                             5'b01001};
   logic [11:0] m_a  [7] = '{12'h000, 12'hA01, 12'hB02, 12'hC03, 12'hD04, 12'h000, 12'hA01};
   logic [11:0] m_b  [7] = '{12'h000, 12'hE05, 12'hE05, 12'hE05, 12'h000, 12'h000, 12'h000};
   logic        m_v  [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

   core_trim_bank u_dut (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .fuse_idx_o(fuse_idx_o), .fuse_data_i(fuse_data_i),
      .dual_edge_i(dual_edge_i), .fg_cal_en_i(fg_cal_en_i), .a_in_sel_b_i(a_in_sel_b_i),
      .a_phase90_i(a_phase90_i), .b_in_sel_b_i(b_in_sel_b_i), .timing_b_o(timing_b_o),
      .timing_b_valid_o(timing_b_valid_o), .ofs_a_o(ofs_a_o), .ofs_b_o(ofs_b_o),
      .trims_ready_o(trims_ready_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, 20 ns period
   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   // Fuse storage answers one edge after the index; reached by the loader only
   always @(posedge sys_clk_i) begin
      fuse_data_i <= (fuse_idx_o < 3'h6) ? rom[fuse_idx_o] : 16'h5A5A;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe, sampled there
   task rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b0;
      #1 d = reg_rdata_o;
   endtask : rd

   // Bounded wait, since a stuck loader must not hang the run
   task wait_ready;
      n = 0;
      while (trims_ready_o !== 1'b1 && n < 40) begin
         @(posedge sys_clk_i);
         n++;
      end
      #1 check({15'h0, trims_ready_o}, 16'h0001);
      check({13'h0, fuse_idx_o}, 16'h0005);
   endtask : wait_ready

   task conclude;
      $display("Counts: checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog, well past the roughly 130 cycles the tests need
   initial begin
      #(20 * 5000);
      fails++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      fails = 0;
      checked = 0;
      nrst_i = 1'b0;
      reg_addr_i = 12'h000;
      reg_wdata_i = 16'h0000;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      {dual_edge_i, fg_cal_en_i, a_in_sel_b_i, a_phase90_i, b_in_sel_b_i} = 5'b00000;
      repeat (5) @(posedge sys_clk_i);
      #1 check({4'h0, ofs_a_o}, 16'h0000);
      check({15'h0, trims_ready_o}, 16'h0000);
      @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      // Write during the fuse walk must be dropped; aimed after the timing
      // default has landed, so a leak would show in the default read
      repeat (3) @(posedge sys_clk_i);
      wr(12'h31B, 16'h0000);
      check({15'h0, trims_ready_o}, 16'h0000);
      wait_ready();
      $display("test reset and load done");

      // Defaults, then write and read back with no gap
      for (int i = 0; i < 8; i++) begin
         rd(r_ad[i], rv);
         check(rv, r_df[i]);
         wr(r_ad[i], r_wd[i]);
         rd(r_ad[i], rv);
         check(rv, r_rb[i]);
      end
      $display("test register rows done");

      // Seven operating states, each picking one trim or zero per core
      for (int i = 0; i < 7; i++) begin
         @(posedge sys_clk_i);
         {dual_edge_i, fg_cal_en_i, a_in_sel_b_i, a_phase90_i, b_in_sel_b_i} <= m_md[i];
         repeat (4) @(posedge sys_clk_i);
         #1 check({4'h0, ofs_a_o}, {4'h0, m_a[i]});
         check({4'h0, ofs_b_o}, {4'h0, m_b[i]});
         check({15'h0, timing_b_valid_o}, {15'h0, m_v[i]});
         check({8'h00, timing_b_o}, 16'h003C);
      end
      $display("test mode rows done");

      // Read data gone the cycle after; then a mid-run reset reloads fuses
      rd(12'h34A, rv);
      check(rv, 16'h3D04);
      @(posedge sys_clk_i);
      #1 check(reg_rdata_o, 16'h0000);
      @(posedge sys_clk_i);
      nrst_i <= 1'b0;
      #1 check({4'h0, ofs_a_o}, 16'h0000);
      check({15'h0, trims_ready_o}, 16'h0000);
      @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      wait_ready();
      rd(12'h344, rv);
      check(rv, 16'hF123);
      repeat (4) @(posedge sys_clk_i);
      #1 check({4'h0, ofs_a_o}, 16'h0123);
      check({8'h00, timing_b_o}, 16'h00A5);
      $display("test mid-run reset done");
      conclude();
   end
endmodule : test_adc_core_trim_registers
